// ===== rtl/pecbc_bist_checker.sv
// checker_locked tracking and self-test error counter
// assumes bit_ok and bit_err from the receive path, same clock
`timescale 1ns/10ps
`include "pecbc_defs.svh"
module pecbc_bist_checker #(
	parameter int LOCK_GOOD = 16
) (
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic        enable,
	input  wire logic        wrap_mode,
	input  wire logic        bit_ok,
	input  wire logic        bit_err,
	output logic             locked,
	output logic             sync_lost_pulse,
	output logic             count_wrap_pulse,
	output logic [15:0]      err_count
);
	import pecbc_pkg::*;
	typedef struct packed {
		pecbc_chk_state_type state;
		logic [7:0]          good;
		logic [15:0]         errs;
		logic                lost;
		logic                wrapped;
	} pecbc_chk_type;
	pecbc_chk_type cur;
	pecbc_chk_type next_cur;
	always_comb begin
		next_cur = cur;
		next_cur.lost = 1'b0;
		next_cur.wrapped = 1'b0;
		case (cur.state)
			PECBC_CHK_OFF: begin
				next_cur.good = 8'h00;
				if (enable) begin
					next_cur.state = PECBC_CHK_HUNT;
				end
			end
			PECBC_CHK_HUNT: begin
				if (bit_err) begin
					next_cur.good = 8'h00;
				end else if (bit_ok) begin
					next_cur.good = cur.good + 8'h01;
					if (cur.good == 8'(LOCK_GOOD - 1)) begin
						next_cur.state = PECBC_CHK_LOCKED;
					end
				end
			end
			PECBC_CHK_LOCKED: begin
				if (bit_err) begin
					if (cur.errs != `PECBC_BIST_ERR_MAX) begin
						next_cur.errs = cur.errs + 16'h0001;
					end else if (wrap_mode) begin
						next_cur.errs = 16'h0000; // R10
						next_cur.wrapped = 1'b1; // R10
					end
					if (cur.errs[3:0] == 4'hF) begin
						// an error while the low four bits of the error total are Fh means the pattern slipped
						next_cur.state = PECBC_CHK_HUNT;
						next_cur.good = 8'h00;
						next_cur.lost = 1'b1;
					end
				end
			end
			default: begin
				next_cur.state = PECBC_CHK_OFF;
			end
		endcase
		if (!enable) begin
			next_cur.state = PECBC_CHK_OFF; // R11
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cur <= '{PECBC_CHK_OFF, 8'h00, 16'h0000, 1'b0, 1'b0};
		end else begin
			cur <= next_cur;
		end
	end
	assign locked = (cur.state == PECBC_CHK_LOCKED);
	assign sync_lost_pulse = cur.lost;
	assign count_wrap_pulse = cur.wrapped;
	assign err_count = cur.errs;
endmodule : pecbc_bist_checker

// ===== rtl/pecbc_defs.svh
// register offsets, field positions, reset values for the diagnostic counter block
// assumes inclusion by both design files
`ifndef PECBC_DEFS_SVH
`define PECBC_DEFS_SVH
`define PECBC_IDX_FALSE_CARRIER   5'h14
`define PECBC_IDX_RX_ERROR        5'h15
`define PECBC_IDX_SELF_TEST       5'h16
`define PECBC_IDX_LOOPBACK_CTRL   5'h17
`define PECBC_FC_MAX              8'hFF
`define PECBC_FC_HALF             8'h7F
`define PECBC_RE_MAX              16'hFFFF
`define PECBC_RE_HALF             16'h7FFF
`define PECBC_ST_WRAP_BIT         14
`define PECBC_ST_PRBS_BIT         13
`define PECBC_ST_GEN_EN_BIT       12
`define PECBC_ST_LOCK_BIT         11
`define PECBC_ST_SYNC_LOST_BIT    10
`define PECBC_ST_GEN_ACT_BIT      9
`define PECBC_ST_POWER_BIT        8
`define PECBC_ST_TX_IN_LB_BIT     6
`define PECBC_ST_RESET            16'h0000
`define PECBC_LB_RESET            5'h00
`define PECBC_IE_RESET            2'h0
`define PECBC_BIST_ERR_MAX        16'hFFFF
`endif

// ===== rtl/pecbc_diag_regs.sv
// apb register bank: false-carrier and receive-error counters, self-test control
// assumes event inputs from phy logic on ref_clk; sleep_mode comes from a pin
//
// Added by the designer: the APB register port.
`timescale 1ns/10ps
`include "pecbc_defs.svh"
// Summary of operation
// R01 - reserved bits ignore writes and read zero
// R02 - eight-bit false-carrier counter advances per false carrier event
// R03 - false-carrier counter holds at FFh
// R04 - false-carrier count passing 7Fh raises half-full event
// R05 - reading either counter returns count then clears it
// R06 - receive error counts symbol errors while receive data valid
// R07 - receive error counter frozen in mii loopback
// R08 - receive error counter holds at FFFFh
// R09 - receive error count passing 7FFFh raises half-full event
// R10 - bit 14 picks wrap-with-pulse or stop-at-max for self-test errors
// R11 - bit 13 picks prbs continuous packets or single constant packet
// R12 - bit 12 enables the packet generator
// R13 - bit 11 shows checker locked
// R14 - bit 10 latches high on checker sync loss
// R15 - bit 9 shows generator active
// R16 - bit 8 shows normal power mode
// R17 - bit 6 forwards mac transmit to line during loopback, 100 Mb/s only
// R18 - half-full events produce interrupts only when enabled
// R19 - loopback select uses one-hot codes
// R20 - event coinciding with clearing read is counted afterwards
module pecbc_diag_regs (
	input  wire logic                         ref_clk,
	input  wire logic                         rst_n,
	input  wire logic                         psel,
	input  wire logic                         penable,
	input  wire logic                         pwrite,
	input  wire logic [11:0]                  paddr,
	input  wire logic [31:0]                  pwdata,
	output logic      [31:0]                  prdata,
	output logic                              pready,
	output logic                              pslverr,
	input  wire logic                         false_carrier_events,
	input  wire logic                         rx_symbol_error,
	input  wire logic                         rx_data_valid,
	input  wire logic                         mii_loopback,
	input  wire logic                         speed_100,
	input  wire logic                         sleep_mode,
	input  wire logic                         false_carrier_halffull_irq_enable,
	input  wire logic                         rx_error_halffull_irq_enable,
	input  wire logic                         chk_bit_ok,
	input  wire logic                         chk_bit_err,
	input  wire logic                         gen_packet_done,
	output logic                              false_carrier_halffull_irq,
	output logic                              rx_error_halffull_irq,
	output logic                              gen_enable,
	output logic                              gen_prbs_payload,
	output logic                              tx_to_line_in_loopback,
	output pecbc_pkg::pecbc_loopback_type     loopback_select,
	output logic                              bist_count_pulse
);
	import pecbc_pkg::*;
	typedef struct packed {
		logic [1:0]  sleep_sync;
		logic [7:0]  fc_count;
		logic [15:0] re_count;
		logic        wrap_sel;
		logic        prbs_sel;
		logic        gen_en;
		logic        gen_active;
		logic        sync_lost;
		logic        tx_in_lb;
		logic [4:0]  lb_sel;
		logic        fc_irq;
		logic        re_irq;
		logic [31:0] rdata;
	} pecbc_regs_type;
	pecbc_regs_type cur;
	pecbc_regs_type next_cur;
	logic        chk_locked;
	logic        chk_lost;
	logic        chk_wrap;
	logic        rd_acc;
	logic        wr_acc;
	logic        addr_ok;
	logic [4:0]  reg_idx;
	logic        chk_enable;
	function automatic logic is_onehot5(input logic [4:0] v);
		return (v != 5'h00) && ((v & (v - 5'h01)) == 5'h00);
	endfunction : is_onehot5
	function automatic logic hits(input logic [4:0] idx, input logic [4:0] want);
		return idx == want;
	endfunction : hits
	// checker runs in prbs mode even with the generator off
	assign chk_enable = cur.prbs_sel; // R11
	pecbc_bist_checker #(
		.LOCK_GOOD (16)
	) u_checker (
		.ref_clk          (ref_clk),
		.rst_n            (rst_n),
		.enable           (chk_enable),
		.wrap_mode        (cur.wrap_sel),
		.bit_ok           (chk_bit_ok),
		.bit_err          (chk_bit_err),
		.locked           (chk_locked),
		.sync_lost_pulse  (chk_lost),
		.count_wrap_pulse (chk_wrap),
		// self-test error total has no register here, so it stays internal
		.err_count        ()
	);
	// byte address = index * 4, registers answer in the setup+access pair
	assign reg_idx = paddr[6:2];
	assign addr_ok = (paddr[11:7] == 5'h00) && (paddr[1:0] == 2'h0) &&
		(hits(reg_idx, `PECBC_IDX_FALSE_CARRIER) || hits(reg_idx, `PECBC_IDX_RX_ERROR) ||
		hits(reg_idx, `PECBC_IDX_SELF_TEST) || hits(reg_idx, `PECBC_IDX_LOOPBACK_CTRL));
	assign rd_acc = psel && penable && !pwrite && addr_ok;
	assign wr_acc = psel && penable && pwrite && addr_ok;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok;
	always_comb begin
		next_cur = cur;
		next_cur.sleep_sync = {cur.sleep_sync[0], sleep_mode};
		next_cur.fc_irq = 1'b0;
		next_cur.re_irq = 1'b0;
		// clear first, then count, so an event in the read cycle survives
		if (rd_acc && hits(reg_idx, `PECBC_IDX_FALSE_CARRIER)) begin
			next_cur.fc_count = 8'h00; // R05
		end
		if (rd_acc && hits(reg_idx, `PECBC_IDX_RX_ERROR)) begin
			next_cur.re_count = 16'h0000; // R05
		end
		if (false_carrier_events && cur.fc_count != `PECBC_FC_MAX) begin // R03
			next_cur.fc_count = next_cur.fc_count + 8'h01; // R02 R20
			if (cur.fc_count == `PECBC_FC_HALF &&
				!(rd_acc && hits(reg_idx, `PECBC_IDX_FALSE_CARRIER))) begin
				next_cur.fc_irq = false_carrier_halffull_irq_enable; // R04 R18
			end
		end else if (false_carrier_events && rd_acc &&
			hits(reg_idx, `PECBC_IDX_FALSE_CARRIER)) begin
			next_cur.fc_count = 8'h01; // R20
		end
		if (rx_symbol_error && rx_data_valid && !mii_loopback) begin // R06 R07
			if (cur.re_count != `PECBC_RE_MAX) begin // R08
				next_cur.re_count = next_cur.re_count + 16'h0001; // R20
				if (cur.re_count == `PECBC_RE_HALF &&
					!(rd_acc && hits(reg_idx, `PECBC_IDX_RX_ERROR))) begin
					next_cur.re_irq = rx_error_halffull_irq_enable; // R09 R18
				end
			end else if (rd_acc && hits(reg_idx, `PECBC_IDX_RX_ERROR)) begin
				next_cur.re_count = 16'h0001; // R20
			end
		end
		if (wr_acc && hits(reg_idx, `PECBC_IDX_SELF_TEST)) begin // R01
			next_cur.wrap_sel = pwdata[`PECBC_ST_WRAP_BIT]; // R10
			next_cur.prbs_sel = pwdata[`PECBC_ST_PRBS_BIT]; // R11
			next_cur.gen_en = pwdata[`PECBC_ST_GEN_EN_BIT]; // R12
			next_cur.tx_in_lb = pwdata[`PECBC_ST_TX_IN_LB_BIT]; // R17
		end
		if (wr_acc && hits(reg_idx, `PECBC_IDX_LOOPBACK_CTRL)) begin
			// codes with two or more bits set are refused so the datapath never sees two loops
			if (is_onehot5(pwdata[4:0]) || pwdata[4:0] == 5'h00) begin
				next_cur.lb_sel = pwdata[4:0]; // R19
			end
		end
		// generator: continuous in prbs mode, one packet otherwise
		if (!cur.gen_en) begin
			next_cur.gen_active = 1'b0; // R12
		end else if (!cur.gen_active && !(wr_acc && hits(reg_idx, `PECBC_IDX_SELF_TEST))) begin
			next_cur.gen_active = 1'b1; // R15
		end else if (gen_packet_done && !cur.prbs_sel) begin
			next_cur.gen_active = 1'b0; // R11
			next_cur.gen_en = 1'b0;
		end
		// latched sync loss survives until read; a new loss wins over the clear
		if (rd_acc && hits(reg_idx, `PECBC_IDX_SELF_TEST)) begin
			next_cur.sync_lost = 1'b0;
		end
		if (chk_lost) begin
			next_cur.sync_lost = 1'b1; // R14
		end
		next_cur.rdata = 32'h0000_0000;
		// capture the values as they become at the setup edge: an event counted
		// there is returned by this read instead of being wiped by its clear
		if (psel && !penable && !pwrite) begin
			case (paddr[6:2])
				`PECBC_IDX_FALSE_CARRIER: next_cur.rdata = {24'h00_0000, next_cur.fc_count}; // R01
				`PECBC_IDX_RX_ERROR: next_cur.rdata = {16'h0000, next_cur.re_count}; // R20
				`PECBC_IDX_SELF_TEST: begin
					next_cur.rdata[`PECBC_ST_WRAP_BIT] = next_cur.wrap_sel;
					next_cur.rdata[`PECBC_ST_PRBS_BIT] = next_cur.prbs_sel;
					next_cur.rdata[`PECBC_ST_GEN_EN_BIT] = next_cur.gen_en;
					next_cur.rdata[`PECBC_ST_LOCK_BIT] = chk_locked; // R13
					next_cur.rdata[`PECBC_ST_SYNC_LOST_BIT] = next_cur.sync_lost; // R14
					next_cur.rdata[`PECBC_ST_GEN_ACT_BIT] = next_cur.gen_active; // R15
					next_cur.rdata[`PECBC_ST_POWER_BIT] = !cur.sleep_sync[1]; // R16
					next_cur.rdata[`PECBC_ST_TX_IN_LB_BIT] = next_cur.tx_in_lb;
				end
				`PECBC_IDX_LOOPBACK_CTRL: next_cur.rdata = {27'h000_0000, cur.lb_sel};
				default: next_cur.rdata = 32'h0000_0000;
			endcase
		end
	end
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end
	assign prdata = cur.rdata;
	assign false_carrier_halffull_irq = cur.fc_irq;
	assign rx_error_halffull_irq = cur.re_irq;
	assign gen_enable = cur.gen_active;
	assign gen_prbs_payload = cur.prbs_sel;
	// only meaningful at 100 Mb/s with mii loopback; software orders the basic control bit first
	assign tx_to_line_in_loopback = cur.tx_in_lb && speed_100 && mii_loopback; // R17
	assign loopback_select = pecbc_loopback_type'(cur.lb_sel);
	assign bist_count_pulse = chk_wrap; // R10
endmodule : pecbc_diag_regs

// ===== rtl/pecbc_pkg.sv
// types shared by the diagnostic counter block
// assumes pecbc_defs.svh for numeric constants
package pecbc_pkg;
	typedef enum logic [4:0] {
		PECBC_LB_NONE      = 5'h00,
		PECBC_LB_PCS_IN    = 5'h01,
		PECBC_LB_PCS_OUT   = 5'h02,
		PECBC_LB_DIGITAL   = 5'h04,
		PECBC_LB_ANALOG    = 5'h08,
		PECBC_LB_REVERSE   = 5'h10
	} pecbc_loopback_type;
	typedef enum logic [1:0] {
		PECBC_CHK_OFF,
		PECBC_CHK_HUNT,
		PECBC_CHK_LOCKED
	} pecbc_chk_state_type;
endpackage : pecbc_pkg

// ===== verif/pecbc_checker.sv
// port assertions for the diagnostic register bank
// assumes binding onto pecbc_diag_regs, one clock, sync reset
`timescale 1ns/10ps
module pecbc_checker (
	input wire logic                          ref_clk,
	input wire logic                          rst_n,
	input wire logic                          psel,
	input wire logic                          penable,
	input wire logic                          pwrite,
	input wire logic [11:0]                   paddr,
	input wire logic [31:0]                   prdata,
	input wire logic                          speed_100,
	input wire logic                          mii_loopback,
	input wire logic                          false_carrier_halffull_irq_enable,
	input wire logic                          rx_error_halffull_irq_enable,
	input wire logic                          false_carrier_halffull_irq,
	input wire logic                          rx_error_halffull_irq,
	input wire logic                          tx_to_line_in_loopback,
	input wire pecbc_pkg::pecbc_loopback_type loopback_select
);
	import pecbc_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	logic rd_acc;
	assign rd_acc = psel && penable && !pwrite;
	property p_up_zero; rd_acc |-> prdata[31:16] == 16'h0000; endproperty
	a_up_zero: assert property (p_up_zero) else $error("upper read bits set");
	property p_fc_rsvd; rd_acc && paddr == 12'h050 |-> prdata[15:8] == 8'h00; endproperty
	a_fc_rsvd: assert property (p_fc_rsvd) else $error("fc reserved bits set");
	property p_st_rsvd; rd_acc && paddr == 12'h058 |-> !prdata[15] && !prdata[7]; endproperty
	a_st_rsvd: assert property (p_st_rsvd) else $error("st reserved bits set");
	property p_tx_lb; tx_to_line_in_loopback |-> speed_100 && mii_loopback; endproperty
	a_tx_lb: assert property (p_tx_lb) else $error("tx to line off mode");
	property p_fc_pulse; false_carrier_halffull_irq |=> !false_carrier_halffull_irq; endproperty
	a_fc_pulse: assert property (p_fc_pulse) else $error("fc event not a pulse");
	property p_re_pulse; rx_error_halffull_irq |=> !rx_error_halffull_irq; endproperty
	a_re_pulse: assert property (p_re_pulse) else $error("re event not a pulse");
	// enable sampled one edge back because the event is registered
	property p_fc_gate; false_carrier_halffull_irq |-> $past(false_carrier_halffull_irq_enable); endproperty
	a_fc_gate: assert property (p_fc_gate) else $error("fc irq while disabled");
	property p_re_gate; rx_error_halffull_irq |-> $past(rx_error_halffull_irq_enable); endproperty
	a_re_gate: assert property (p_re_gate) else $error("re irq while disabled");
	property p_onehot; $onehot0(loopback_select); endproperty
	a_onehot: assert property (p_onehot) else $error("loopback not one-hot");
endmodule : pecbc_checker
bind pecbc_diag_regs pecbc_checker u_chk (.ref_clk, .rst_n, .psel, .penable, .pwrite,
	.paddr, .prdata, .speed_100, .mii_loopback, .false_carrier_halffull_irq_enable,
	.rx_error_halffull_irq_enable, .false_carrier_halffull_irq, .rx_error_halffull_irq,
	.tx_to_line_in_loopback, .loopback_select);

// ===== verif/pecbc_phy_model.sv
// behavioural phy-side event source for the diagnostic register bank
// assumes emit is called just after a rising edge of ref_clk
`timescale 1ns/10ps
module pecbc_phy_model (
	input  wire logic ref_clk,
	output logic      fc_evt,
	output logic      sym_err,
	output logic      bit_ok,
	output logic      bit_err,
	output logic      pkt_done
);
	initial begin
		{fc_evt, sym_err, bit_ok, bit_err, pkt_done} = 5'h00;
	end
	// one event per cycle per mask bit; idle edges after let status flops settle
	task automatic emit(input logic [4:0] mask, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge ref_clk);
			{fc_evt, sym_err, bit_ok, bit_err, pkt_done} <= mask;
		end
		@(posedge ref_clk);
		{fc_evt, sym_err, bit_ok, bit_err, pkt_done} <= 5'h00;
		repeat (2) @(posedge ref_clk);
	endtask : emit
endmodule : pecbc_phy_model

// ===== verif/testbench.sv
// self-checking bench for the diagnostic register bank
// assumes pecbc_phy_model for events; apb master lives here
`timescale 1ns/10ps
module testbench;
	import pecbc_pkg::*;
	logic               ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, e;
	logic [11:0]        paddr;
	logic [31:0]        pwdata, prdata, d;
	logic               rx_data_valid, mii_loopback, speed_100, sleep_mode, fc_en, re_en;
	logic               fc_evt, sym_err, bit_ok, bit_err, pkt_done;
	logic               fc_irq, re_irq, gen_en, gen_prbs, tx_lb, bist_pulse;
	pecbc_loopback_type lb_sel;
	int                 err_count, checks, fc_irqs, re_irqs;
	pecbc_diag_regs DUT (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .false_carrier_events(fc_evt), .rx_symbol_error(sym_err),
		.rx_data_valid, .mii_loopback, .speed_100, .sleep_mode,
		.false_carrier_halffull_irq_enable(fc_en), .rx_error_halffull_irq_enable(re_en),
		.chk_bit_ok(bit_ok), .chk_bit_err(bit_err), .gen_packet_done(pkt_done),
		.false_carrier_halffull_irq(fc_irq), .rx_error_halffull_irq(re_irq),
		.gen_enable(gen_en), .gen_prbs_payload(gen_prbs), .tx_to_line_in_loopback(tx_lb),
		.loopback_select(lb_sel), .bist_count_pulse(bist_pulse));
	pecbc_phy_model phy (.ref_clk, .fc_evt, .sym_err, .bit_ok, .bit_err, .pkt_done);
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		fc_irqs += int'(fc_irq === 1'b1);
		re_irqs += int'(re_irq === 1'b1);
	end
	task automatic results();
		$display("checks %0d errors %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : results
	task automatic check(input string n, input logic [31:0] seen, input logic [31:0] x);
		checks++;
		if (seen !== x) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", n, x, seen);
		end
	endtask : check
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] v);
		int n;
		@(posedge ref_clk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, v};
		@(posedge ref_clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			err_count++;
			results();
		end
		d = prdata;
		e = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb
	task automatic rdchk(input string n, input logic [11:0] a, input logic [31:0] x,
		input logic [31:0] m = 32'hFFFFFFFF);
		apb(1'b0, a, 32'h0);
		check(n, d & m, x);
	endtask : rdchk
	task automatic t_fc();
		fc_en <= 1'b1;
		phy.emit(5'h10, 128);
		rdchk("fc half", 12'h050, 32'h80);
		check("fc irq", fc_irqs, 1);
		rdchk("fc cleared", 12'h050, 32'h0);
		apb(1'b1, 12'h050, 32'hFFFF);
		rdchk("fc write", 12'h050, 32'h0);
		phy.emit(5'h10, 300);
		rdchk("fc sat", 12'h050, 32'hFF);
		fc_en <= 1'b0;
		phy.emit(5'h10, 129);
		check("fc gate", fc_irqs, 2);
		// event lands on the clearing access edge
		fork
			rdchk("fc before", 12'h050, 32'h81);
			begin
				@(posedge ref_clk);
				phy.emit(5'h10, 1);
			end
		join
		rdchk("fc kept", 12'h050, 32'h1);
		// event lands on the setup edge of the clearing read
		fork
			rdchk("fc setup", 12'h050, 32'h1);
			phy.emit(5'h10, 1);
		join
		rdchk("fc after", 12'h050, 32'h0);
	endtask : t_fc
	task automatic t_re();
		re_en <= 1'b1;
		phy.emit(5'h08, 5);
		{mii_loopback, rx_data_valid} <= 2'b11;
		phy.emit(5'h08, 5);
		mii_loopback <= 1'b0;
		rdchk("re gated", 12'h054, 32'h0);
		phy.emit(5'h08, 7);
		rdchk("re count", 12'h054, 32'h7);
		phy.emit(5'h08, 65540);
		rdchk("re sat", 12'h054, 32'hFFFF);
		check("re irq", re_irqs, 1);
	endtask : t_re
	task automatic t_st();
		{mii_loopback, speed_100} <= 2'b11;
		apb(1'b1, 12'h058, 32'hFFFF);
		rdchk("st all", 12'h058, 32'h7340);
		check("gen on", gen_en, 1'b1);
		check("prbs on", gen_prbs, 1'b1);
		check("tx line", tx_lb, 1'b1);
		speed_100 <= 1'b0;
		phy.emit(5'h04, 16);
		check("tx line 10", tx_lb, 1'b0);
		rdchk("lock", 12'h058, 32'h800, 32'hC00);
		check("bist idle", bist_pulse, 1'b0);
		phy.emit(5'h02, 16);
		rdchk("sync lost", 12'h058, 32'h400, 32'hC00);
		rdchk("sync read", 12'h058, 32'h0, 32'h400);
		apb(1'b1, 12'h058, 32'h1000);
		repeat (2) @(posedge ref_clk);
		check("gen single", gen_en, 1'b1);
		check("prbs off", gen_prbs, 1'b0);
		phy.emit(5'h01, 1);
		check("gen done", gen_en, 1'b0);
		rdchk("gen idle", 12'h058, 32'h0, 32'h3200);
		{mii_loopback, sleep_mode} <= 2'b01;
		repeat (4) @(posedge ref_clk);
		rdchk("sleep", 12'h058, 32'h0, 32'h100);
		sleep_mode <= 1'b0;
	endtask : t_st
	task automatic t_lb();
		logic [4:0] code;
		for (int i = 0; i < 5; i++) begin
			code = 5'h01 << i;
			apb(1'b1, 12'h05C, {27'h0, code});
			rdchk("loopback", 12'h05C, {27'h0, code});
			check("lb pin", {27'h0, lb_sel}, {27'h0, code});
		end
		apb(1'b1, 12'h05C, 32'h3);
		rdchk("lb bad", 12'h05C, 32'h10);
		apb(1'b0, 12'h070, 32'h0);
		check("unmapped err", e, 1'b1);
		check("unmapped data", d, 32'h0);
	endtask : t_lb
	initial begin
		{rst_n, psel, penable, pwrite, rx_data_valid, mii_loopback} = 6'h00;
		{speed_100, sleep_mode, fc_en, re_en} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (3) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rdchk("fc reset", 12'h050, 32'h0);
		rdchk("st reset", 12'h058, 32'h100);
		t_fc();
		t_re();
		t_st();
		t_lb();
		results();
	end
endmodule : testbench
